// ---- pkg/sync_follow_pkg.sv ----
// Package with register map, field layout, reset values and timing for the setpoint follower.
// Operation
// - Mode value 8 selects position following.
// - Mode value 9 selects velocity following.
// - Position mode tracks absolute target, no ramp.
// - Velocity mode follows speed target, no ramp.
// - Repeated identical targets give identical motion.
// - No start bit; no mode-specific control bits.
// - Status bit 8 shows fieldbus synchronisation.
// - Position mode: bit 12 shows target used.
// - Velocity mode: bit 12 shows target followed.
// - Bit 10 unused; bit 13 unused in velocity.
// - Symmetric configurable corridor around demand position.
// - In closed loop, outside corridor beyond timeout sets bit 13.
// - Bit 11 flags demand beyond software limits.
// - Commanded position held within software limits.
// - Range limit setting handles position overrun/underrun.
// - Quick stop brakes, then runs selected option; the coast option skips braking and disables at once.
// - Speed capped; position mode only closed loop.
// - Cycle equals period times ten^index seconds.
// - Only index -3 accepted: millisecond units.
// - Position, velocity and torque offsets applied.
// - Lock onto SYNC once Operational.
// - Actual values readable per mode.
package sync_follow_pkg;

  // Register byte offsets on the 32-bit bus.
  localparam logic [7:0] OFS_MODE       = 8'h00;
  localparam logic [7:0] OFS_CONTROL    = 8'h04;
  localparam logic [7:0] OFS_STATUS     = 8'h08;
  localparam logic [7:0] OFS_TGT_POS    = 8'h0C;
  localparam logic [7:0] OFS_TGT_VEL    = 8'h10;
  localparam logic [7:0] OFS_POS_OFS    = 8'h14;
  localparam logic [7:0] OFS_VEL_OFS    = 8'h18;
  localparam logic [7:0] OFS_TRQ_OFS    = 8'h1C;
  localparam logic [7:0] OFS_SW_MIN     = 8'h20;
  localparam logic [7:0] OFS_SW_MAX     = 8'h24;
  localparam logic [7:0] OFS_RANGE_MIN  = 8'h28;
  localparam logic [7:0] OFS_RANGE_MAX  = 8'h2C;
  localparam logic [7:0] OFS_FE_WINDOW  = 8'h30;
  localparam logic [7:0] OFS_FE_TIMEOUT = 8'h34;
  localparam logic [7:0] OFS_QS_DECEL   = 8'h38;
  localparam logic [7:0] OFS_MAX_SPEED  = 8'h3C;
  localparam logic [7:0] OFS_IP_PERIOD  = 8'h40;
  localparam logic [7:0] OFS_IP_INDEX   = 8'h44;
  localparam logic [7:0] OFS_ACT_POS    = 8'h48;
  localparam logic [7:0] OFS_ACT_VEL    = 8'h4C;
  localparam logic [7:0] OFS_FE_ACT     = 8'h50;
  localparam logic [7:0] OFS_POLARITY   = 8'h54;
  localparam logic [7:0] OFS_DEM_POS    = 8'h58;
  localparam logic [7:0] OFS_DEM_VEL    = 8'h5C;

  // Mode selection codes.
  localparam logic [7:0] MODE_CSP = 8'h08;
  localparam logic [7:0] MODE_CSV = 8'h09;

  // Control register field positions.
  localparam int CTL_OPERATIONAL = 0;
  localparam int CTL_CLOSED_LOOP = 1;
  localparam int CTL_QUICK_STOP  = 2;
  localparam int CTL_RANGE_WRAP  = 3;
  localparam int CTL_QS_OPT_LO   = 4;

  // Quick-stop option codes.
  localparam logic [1:0] QS_OPT_COAST    = 2'h0;
  localparam logic [1:0] QS_OPT_DISABLE  = 2'h1;
  localparam logic [1:0] QS_OPT_HOLD     = 2'h2;

  // Status word bit positions.
  localparam int SW_SYNC   = 8;
  localparam int SW_LIMIT  = 11;
  localparam int SW_FOLLOW = 12;
  localparam int SW_FERR   = 13;

  // Reset values.
  localparam logic [7:0]  RST_IP_PERIOD = 8'h01;
  localparam logic [7:0]  RST_IP_INDEX  = 8'hFD;
  localparam logic [31:0] RST_SW_MIN    = 32'h80000000;
  localparam logic [31:0] RST_SW_MAX    = 32'h7FFFFFFF;
  localparam logic [31:0] RST_MAX_SPEED = 32'h7FFFFFFF;

  // Timing: the cycle base is one millisecond at a 10 ns clock.
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_TIME_NS    = 1000000;
  localparam int MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;

endpackage

// ---- hw/sync_setpoint_follower.sv ----
// Cyclic synchronous position and velocity setpoint follower with an Avalon-MM register slave.
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
module sync_setpoint_follower #(
  parameter int MS_CYCLES_P = sync_follow_pkg::MS_CYCLES
) (
  // Clock and reset.
  input  wire  logic        clk_i,
  input  wire  logic        sys_rst_i,
  // Avalon-MM register slave.
  input  wire  logic [7:0]  avs_address_i,
  input  wire  logic        avs_read_i,
  input  wire  logic        avs_write_i,
  input  wire  logic [31:0] avs_writedata_i,
  output logic        [31:0] avs_readdata_o,
  output logic              avs_waitrequest_o,
  // Fieldbus timing and measured feedback.
  input  wire  logic        sync_i,
  input  wire  logic [31:0] act_pos_i,
  input  wire  logic [31:0] act_vel_i,
  // Drive demand, cycle tick and status word outputs.
  output logic        [31:0] demand_pos_o,
  output logic        [31:0] demand_vel_o,
  output logic        [15:0] torque_offset_o,
  output logic              drive_enable_o,
  output logic              cycle_tick_o,
  output logic        [15:0] statusword_o
);
  import sync_follow_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Limits a signed value to the window [lo, hi].
  function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
                                        input logic [31:0] hi);
    if ($signed(v) < $signed(lo)) begin
      clamp = lo;
    end else if ($signed(v) > $signed(hi)) begin
      clamp = hi;
    end else begin
      clamp = v;
    end
  endfunction

  // Magnitude of a signed value.
  function automatic logic [31:0] mag(input logic [31:0] v);
    mag = v[31] ? (32'h0 - v) : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [7:0]  mode_r,      mode_nxt;
  logic [7:0]  ctl_r,       ctl_nxt;
  logic [31:0] tgt_pos_r,   tgt_pos_nxt;
  logic [31:0] tgt_vel_r,   tgt_vel_nxt;
  logic [31:0] pos_ofs_r,   pos_ofs_nxt;
  logic [31:0] vel_ofs_r,   vel_ofs_nxt;
  logic [15:0] trq_ofs_r,   trq_ofs_nxt;
  logic [31:0] sw_min_r,    sw_min_nxt;
  logic [31:0] sw_max_r,    sw_max_nxt;
  logic [31:0] rng_min_r,   rng_min_nxt;
  logic [31:0] rng_max_r,   rng_max_nxt;
  logic [31:0] fe_win_r,    fe_win_nxt;
  logic [31:0] fe_tmo_r,    fe_tmo_nxt;
  logic [31:0] qs_dec_r,    qs_dec_nxt;
  logic [31:0] max_spd_r,   max_spd_nxt;
  logic [7:0]  ip_per_r,    ip_per_nxt;
  logic [7:0]  ip_idx_r,    ip_idx_nxt;
  logic [1:0]  polarity_r,  polarity_nxt;
  logic        wait_r,      wait_nxt;
  logic [31:0] rdata_r,     rdata_nxt;
  logic        fresh_r,     fresh_nxt;
  logic        bus_wr;
  logic [31:0] rd_mux;

  // Motion and timing state.
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_FOLLOW = 2'b01,
    ST_QSTOP  = 2'b10,
    ST_HALTED = 2'b11
  } motion_e;

  motion_e     state_r,     state_nxt;
  logic [31:0] ms_cnt_r,    ms_cnt_nxt;
  logic [7:0]  cyc_cnt_r,   cyc_cnt_nxt;
  logic [8:0]  sync_age_r,  sync_age_nxt;
  logic        in_sync_r,   in_sync_nxt;
  logic [31:0] set_pos_r,   set_pos_nxt;
  logic [31:0] set_vel_r,   set_vel_nxt;
  logic [31:0] dem_pos_r,   dem_pos_nxt;
  logic [31:0] dem_vel_r,   dem_vel_nxt;
  logic [31:0] fe_act_r,    fe_act_nxt;
  logic [31:0] fe_cnt_r,    fe_cnt_nxt;
  logic        ferr_r,      ferr_nxt;
  logic        limit_r,     limit_nxt;
  logic        enable_r,    enable_nxt;
  logic        tick_r,      tick_nxt;
  logic [15:0] status_r,    status_nxt;
  logic        ms_tick;
  logic        boundary;
  logic        mode_ok;
  logic        pos_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then the answer at the following edge.

  assign bus_wr   = avs_write_i & ~wait_r;
  assign pos_mode = (mode_r == MODE_CSP);
  assign mode_ok  = pos_mode | (mode_r == MODE_CSV);

  // Read multiplexer over all mapped registers; unmapped reads give zero.
  always_comb begin
    case (avs_address_i)
      OFS_MODE:       rd_mux = {24'h0, mode_r};
      OFS_CONTROL:    rd_mux = {24'h0, ctl_r};
      OFS_STATUS:     rd_mux = {16'h0, status_r};
      OFS_TGT_POS:    rd_mux = tgt_pos_r;
      OFS_TGT_VEL:    rd_mux = tgt_vel_r;
      OFS_POS_OFS:    rd_mux = pos_ofs_r;
      OFS_VEL_OFS:    rd_mux = vel_ofs_r;
      OFS_TRQ_OFS:    rd_mux = {16'h0, trq_ofs_r};
      OFS_SW_MIN:     rd_mux = sw_min_r;
      OFS_SW_MAX:     rd_mux = sw_max_r;
      OFS_RANGE_MIN:  rd_mux = rng_min_r;
      OFS_RANGE_MAX:  rd_mux = rng_max_r;
      OFS_FE_WINDOW:  rd_mux = fe_win_r;
      OFS_FE_TIMEOUT: rd_mux = fe_tmo_r;
      OFS_QS_DECEL:   rd_mux = qs_dec_r;
      OFS_MAX_SPEED:  rd_mux = max_spd_r;
      OFS_IP_PERIOD:  rd_mux = {24'h0, ip_per_r};
      OFS_IP_INDEX:   rd_mux = {24'h0, ip_idx_r};
      OFS_ACT_POS:    rd_mux = pos_mode ? act_pos_i : 32'h0;
      OFS_ACT_VEL:    rd_mux = act_vel_i;
      OFS_FE_ACT:     rd_mux = pos_mode ? fe_act_r : 32'h0;
      OFS_POLARITY:   rd_mux = {30'h0, polarity_r};
      OFS_DEM_POS:    rd_mux = dem_pos_r;
      OFS_DEM_VEL:    rd_mux = dem_vel_r;
      default:        rd_mux = 32'h0;
    endcase
  end

  // Register writes and bus handshake.
  always_comb begin
    mode_nxt     = mode_r;
    ctl_nxt      = ctl_r;
    tgt_pos_nxt  = tgt_pos_r;
    tgt_vel_nxt  = tgt_vel_r;
    pos_ofs_nxt  = pos_ofs_r;
    vel_ofs_nxt  = vel_ofs_r;
    trq_ofs_nxt  = trq_ofs_r;
    sw_min_nxt   = sw_min_r;
    sw_max_nxt   = sw_max_r;
    rng_min_nxt  = rng_min_r;
    rng_max_nxt  = rng_max_r;
    fe_win_nxt   = fe_win_r;
    fe_tmo_nxt   = fe_tmo_r;
    qs_dec_nxt   = qs_dec_r;
    max_spd_nxt  = max_spd_r;
    ip_per_nxt   = ip_per_r;
    ip_idx_nxt   = ip_idx_r;
    polarity_nxt = polarity_r;
    wait_nxt     = ~((avs_read_i | avs_write_i) & wait_r);
    rdata_nxt    = (avs_read_i & wait_r) ? rd_mux : rdata_r;
    // A boundary consumes the fresh mark; a write in the same cycle wins.
    fresh_nxt    = boundary ? 1'b0 : fresh_r;
    if (bus_wr) begin
      case (avs_address_i)
        OFS_MODE:       mode_nxt     = avs_writedata_i[7:0];
        OFS_CONTROL:    ctl_nxt      = avs_writedata_i[7:0];
        OFS_TGT_POS: begin
          tgt_pos_nxt = avs_writedata_i;
          fresh_nxt   = 1'b1;
        end
        OFS_TGT_VEL: begin
          tgt_vel_nxt = avs_writedata_i;
          fresh_nxt   = 1'b1;
        end
        OFS_POS_OFS:    pos_ofs_nxt  = avs_writedata_i;
        OFS_VEL_OFS:    vel_ofs_nxt  = avs_writedata_i;
        OFS_TRQ_OFS:    trq_ofs_nxt  = avs_writedata_i[15:0];
        OFS_SW_MIN:     sw_min_nxt   = avs_writedata_i;
        OFS_SW_MAX:     sw_max_nxt   = avs_writedata_i;
        OFS_RANGE_MIN:  rng_min_nxt  = avs_writedata_i;
        OFS_RANGE_MAX:  rng_max_nxt  = avs_writedata_i;
        OFS_FE_WINDOW:  fe_win_nxt   = avs_writedata_i;
        OFS_FE_TIMEOUT: fe_tmo_nxt   = avs_writedata_i;
        OFS_QS_DECEL:   qs_dec_nxt   = avs_writedata_i;
        OFS_MAX_SPEED:  max_spd_nxt  = avs_writedata_i;
        OFS_IP_PERIOD:  ip_per_nxt   = avs_writedata_i[7:0];
        OFS_IP_INDEX: begin
          // Only the millisecond base is supported; other values are dropped.
          if (avs_writedata_i[7:0] == RST_IP_INDEX) begin
            ip_idx_nxt = avs_writedata_i[7:0];
          end
        end
        OFS_POLARITY:   polarity_nxt = avs_writedata_i[1:0];
        default:        ;
      endcase
    end
  end

  // Register file flip-flops.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mode_r     <= 8'h00;
      ctl_r      <= 8'h00;
      tgt_pos_r  <= 32'h0;
      tgt_vel_r  <= 32'h0;
      pos_ofs_r  <= 32'h0;
      vel_ofs_r  <= 32'h0;
      trq_ofs_r  <= 16'h0;
      sw_min_r   <= RST_SW_MIN;
      sw_max_r   <= RST_SW_MAX;
      rng_min_r  <= RST_SW_MIN;
      rng_max_r  <= RST_SW_MAX;
      fe_win_r   <= 32'h0;
      fe_tmo_r   <= 32'h0;
      qs_dec_r   <= 32'h0;
      max_spd_r  <= RST_MAX_SPEED;
      ip_per_r   <= RST_IP_PERIOD;
      ip_idx_r   <= RST_IP_INDEX;
      polarity_r <= 2'h0;
      wait_r     <= 1'b1;
      rdata_r    <= 32'h0;
      fresh_r    <= 1'b0;
    end else begin
      mode_r     <= mode_nxt;
      ctl_r      <= ctl_nxt;
      tgt_pos_r  <= tgt_pos_nxt;
      tgt_vel_r  <= tgt_vel_nxt;
      pos_ofs_r  <= pos_ofs_nxt;
      vel_ofs_r  <= vel_ofs_nxt;
      trq_ofs_r  <= trq_ofs_nxt;
      sw_min_r   <= sw_min_nxt;
      sw_max_r   <= sw_max_nxt;
      rng_min_r  <= rng_min_nxt;
      rng_max_r  <= rng_max_nxt;
      fe_win_r   <= fe_win_nxt;
      fe_tmo_r   <= fe_tmo_nxt;
      qs_dec_r   <= qs_dec_nxt;
      max_spd_r  <= max_spd_nxt;
      ip_per_r   <= ip_per_nxt;
      ip_idx_r   <= ip_idx_nxt;
      polarity_r <= polarity_nxt;
      wait_r     <= wait_nxt;
      rdata_r    <= rdata_nxt;
      fresh_r    <= fresh_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle timing: millisecond base, cycle counter and SYNC lock.

  assign ms_tick  = (ms_cnt_r == 32'(MS_CYCLES_P - 1));
  // Once operational, SYNC marks the cycle; while not locked, the counter marks it too.
  assign boundary = (ctl_r[CTL_OPERATIONAL] & sync_i) |
                    (~in_sync_r & ms_tick & (cyc_cnt_r + 8'h01 >= ip_per_r));

  // Next values of the timing counters.
  always_comb begin
    ms_cnt_nxt   = ms_tick ? 32'h0 : ms_cnt_r + 32'h1;
    cyc_cnt_nxt  = cyc_cnt_r;
    sync_age_nxt = sync_age_r;
    in_sync_nxt  = in_sync_r;
    if (boundary) begin
      cyc_cnt_nxt = 8'h00;
    end else if (ms_tick) begin
      cyc_cnt_nxt = cyc_cnt_r + 8'h01;
    end
    if (ctl_r[CTL_OPERATIONAL] & sync_i) begin
      // A SYNC no later than one period after the next millisecond tick keeps the lock.
      in_sync_nxt  = 1'b1;
      sync_age_nxt = 9'h000;
    end else if (ms_tick && sync_age_r != 9'h1FF) begin
      sync_age_nxt = sync_age_r + 9'h001;
    end
    if (~ctl_r[CTL_OPERATIONAL] || sync_age_r > {1'b0, ip_per_r}) begin
      in_sync_nxt = 1'b0;
    end
  end

  // Timing flip-flops.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ms_cnt_r   <= 32'h0;
      cyc_cnt_r  <= 8'h00;
      sync_age_r <= 9'h1FF;
      in_sync_r  <= 1'b0;
    end else begin
      ms_cnt_r   <= ms_cnt_nxt;
      cyc_cnt_r  <= cyc_cnt_nxt;
      sync_age_r <= sync_age_nxt;
      in_sync_r  <= in_sync_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Motion: latch set values, apply offsets and limits, quick stop, error check.

  always_comb begin
    logic [31:0] cmd;
    logic [31:0] span;
    logic [31:0] step;
    logic [31:0] lim;
    logic [31:0] err;
    cmd          = 32'h0;
    span         = rng_max_r - rng_min_r + 32'h1;
    step         = 32'h0;
    lim          = 32'h0;
    err          = dem_pos_r - act_pos_i;
    state_nxt    = state_r;
    set_pos_nxt  = set_pos_r;
    set_vel_nxt  = set_vel_r;
    dem_pos_nxt  = dem_pos_r;
    dem_vel_nxt  = dem_vel_r;
    limit_nxt    = limit_r;
    enable_nxt   = enable_r;
    tick_nxt     = boundary;
    fe_act_nxt   = err;
    fe_cnt_nxt   = fe_cnt_r;
    ferr_nxt     = 1'b0;
    // The newest written set value is captured once per cycle and held.
    if (boundary) begin
      set_pos_nxt = tgt_pos_r;
      set_vel_nxt = tgt_vel_r;
    end
    case (state_r)
      ST_IDLE: begin
        enable_nxt  = 1'b0;
        dem_vel_nxt = 32'h0;
        dem_pos_nxt = act_pos_i;
        limit_nxt   = 1'b0;
        if (mode_ok && ~ctl_r[CTL_QUICK_STOP]) begin
          state_nxt = ST_FOLLOW;
        end
      end
      ST_FOLLOW: begin
        enable_nxt = 1'b1;
        if (pos_mode) begin
          // Absolute target plus offset, moved by one range span when past a range end, then clamped.
          cmd = set_pos_r + pos_ofs_r;
          if (ctl_r[CTL_RANGE_WRAP] && $signed(cmd) > $signed(rng_max_r)) begin
            cmd = cmd - span;
          end else if (ctl_r[CTL_RANGE_WRAP] && $signed(cmd) < $signed(rng_min_r)) begin
            cmd = cmd + span;
          end
          limit_nxt = ($signed(cmd) < $signed(sw_min_r)) ||
                      ($signed(cmd) > $signed(sw_max_r));
          cmd       = clamp(cmd, sw_min_r, sw_max_r);
          step      = cmd - dem_pos_r;
          if (ctl_r[CTL_CLOSED_LOOP]) begin
            step = clamp(step, 32'h0 - max_spd_r, max_spd_r);
          end
          // Direct tracking: the demand jumps, limited only by the speed cap.
          if (ms_tick) begin
            dem_pos_nxt = dem_pos_r + step;
            dem_vel_nxt = step;
          end
        end else begin
          cmd         = set_vel_r + vel_ofs_r;
          cmd         = polarity_r[1] ? (32'h0 - cmd) : cmd;
          dem_vel_nxt = clamp(cmd, 32'h0 - max_spd_r, max_spd_r);
          dem_pos_nxt = act_pos_i;
          limit_nxt   = 1'b0;
        end
        if (ctl_r[CTL_QUICK_STOP]) begin
          state_nxt   = ST_QSTOP;
          dem_vel_nxt = act_vel_i;
          if (ctl_r[CTL_QS_OPT_LO +: 2] == QS_OPT_COAST) begin
            state_nxt  = ST_HALTED;
            enable_nxt = 1'b0;
          end
        end else if (!mode_ok) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_QSTOP: begin
        // Brake toward zero speed by the deceleration once per millisecond.
        if (ms_tick) begin
          lim = mag(dem_vel_r);
          if (lim <= qs_dec_r) begin
            dem_vel_nxt = 32'h0;
            state_nxt   = ST_HALTED;
            enable_nxt  = (ctl_r[CTL_QS_OPT_LO +: 2] == QS_OPT_HOLD);
          end else begin
            dem_vel_nxt = dem_vel_r[31] ? dem_vel_r + qs_dec_r
                                        : dem_vel_r - qs_dec_r;
          end
          dem_pos_nxt = dem_pos_r + dem_vel_r;
        end
      end
      ST_HALTED: begin
        dem_vel_nxt = 32'h0;
        if (~ctl_r[CTL_QUICK_STOP]) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // Corridor watch counts whole milliseconds outside the window.
    if (pos_mode && state_r != ST_IDLE && ctl_r[CTL_CLOSED_LOOP] && mag(err) > fe_win_r) begin
      if (ms_tick && fe_cnt_r != 32'hFFFFFFFF) begin
        fe_cnt_nxt = fe_cnt_r + 32'h1;
      end
    end else begin
      fe_cnt_nxt = 32'h0;
    end
    ferr_nxt   = pos_mode && (fe_cnt_r > fe_tmo_r);
    status_nxt = 16'h0;
    status_nxt[SW_SYNC]   = in_sync_r;
    status_nxt[SW_LIMIT]  = pos_mode & limit_r;
    status_nxt[SW_FOLLOW] = (state_r == ST_FOLLOW);
    status_nxt[SW_FERR]   = pos_mode & ferr_r;
  end

  // Motion flip-flops.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_r   <= ST_IDLE;
      set_pos_r <= 32'h0;
      set_vel_r <= 32'h0;
      dem_pos_r <= 32'h0;
      dem_vel_r <= 32'h0;
      fe_act_r  <= 32'h0;
      fe_cnt_r  <= 32'h0;
      ferr_r    <= 1'b0;
      limit_r   <= 1'b0;
      enable_r  <= 1'b0;
      tick_r    <= 1'b0;
      status_r  <= 16'h0;
    end else begin
      state_r   <= state_nxt;
      set_pos_r <= set_pos_nxt;
      set_vel_r <= set_vel_nxt;
      dem_pos_r <= dem_pos_nxt;
      dem_vel_r <= dem_vel_nxt;
      fe_act_r  <= fe_act_nxt;
      fe_cnt_r  <= fe_cnt_nxt;
      ferr_r    <= ferr_nxt;
      limit_r   <= limit_nxt;
      enable_r  <= enable_nxt;
      tick_r    <= tick_nxt;
      status_r  <= status_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop.

  assign avs_readdata_o    = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign demand_pos_o      = dem_pos_r;
  assign demand_vel_o      = dem_vel_r;
  assign torque_offset_o   = trq_ofs_r;
  assign drive_enable_o    = enable_r;
  assign cycle_tick_o      = tick_r;
  assign statusword_o      = status_r;

endmodule

// ---- testbench/sync_follow_properties.sv ----
// Checker of bus answer timing, cycle ticks and status word bits of the follower.
module sync_follow_properties
  import sync_follow_pkg::*;
(
  // Watched ports of the follower.
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        sync_i,
  input wire logic        cycle_tick_o,
  input wire logic [15:0] torque_offset_o,
  input wire logic [15:0] statusword_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // Each property but the two unused-bit checks and the two single-cycle checks ties an output to its cause with an exact cycle figure.
  a_answer_next: assert property (
    $rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o) else $error("bus answer late");
  a_answer_single: assert property (
    !avs_waitrequest_o |=> avs_waitrequest_o) else $error("bus answer too long");
  a_tick_after_sync: assert property (
    statusword_o[SW_SYNC] && sync_i |=> cycle_tick_o) else $error("tick missing");
  a_tick_single: assert property (
    cycle_tick_o |=> !cycle_tick_o) else $error("tick too long");
  a_sync_bit_cause: assert property (
    $rose(statusword_o[SW_SYNC]) |-> $past(sync_i, 2)) else $error("sync bit without SYNC");
  a_bit_ten_free: assert property (
    statusword_o[10] == 1'b0) else $error("bit 10 set");
  a_spare_bits_zero: assert property (
    statusword_o[7:0] == 8'h00 && statusword_o[15:14] == 2'h0) else $error("spare bit set");
  a_torque_cause: assert property (
    $changed(torque_offset_o) |-> $past(avs_write_i && avs_address_i == OFS_TRQ_OFS))
    else $error("torque offset changed without write");
endmodule
bind sync_setpoint_follower sync_follow_properties u_chk (.*);

// ---- testbench/fieldbus_master_model.sv ----
// Cyclic master model giving regular SYNC pulses and fixed feedback.
module fieldbus_master_model (
  // Clock, reset, run enable, SYNC and feedback.
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        run_i,
  output logic             sync_o,
  output logic [31:0]      act_pos_o,
  output logic [31:0]      act_vel_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic       sync_nxt;
  // Ten clocks make one millisecond at the shortened tick, one SYNC each.
  // SYNC lands mid-millisecond, so it never sits next to a counter boundary.
  always_comb begin
    cnt_nxt  = (cnt_r == 4'h9) ? 4'h0 : cnt_r + 4'h1;
    sync_nxt = run_i && (cnt_r == 4'h4);
  end
  // Registers the counter and the one-cycle SYNC pulse.
  always_ff @(posedge clk_i) begin
    cnt_r  <= sys_rst_i ? 4'h0 : cnt_nxt;
    sync_o <= sys_rst_i ? 1'b0 : sync_nxt;
  end
  // The axis stands still at zero, so any demand away from zero is an error.
  assign act_pos_o = 32'h0;
  assign act_vel_o = 32'h0;
endmodule

// ---- testbench/cyclic_sync_setpoint_follower_bench.sv ----
// Register-level bench of the setpoint follower driven by a cyclic master model.
module cyclic_sync_setpoint_follower_bench import sync_follow_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i, sys_rst_i, avs_read_i, avs_write_i, sync_i, sync_run;
  logic        avs_waitrequest_o, drive_enable_o, cycle_tick_o;
  logic [7:0]  avs_address_i;
  logic [15:0] torque_offset_o, statusword_o;
  logic [31:0] avs_writedata_i, avs_readdata_o, act_pos_i, act_vel_i, demand_pos_o, demand_vel_o;
  int          n_errors, comparisons;
  sync_setpoint_follower #(.MS_CYCLES_P(10)) uut (.*);
  fieldbus_master_model master (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .run_i(sync_run),
    .sync_o(sync_i), .act_pos_o(act_pos_i), .act_vel_o(act_vel_i));
  // Free-running 100 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Prints the verdict and ends the run.
  task automatic stop_test;
    if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Compares one value and reports a mismatch.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus access; a read compares the data taken at the answer edge with d.
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input string nm);
    int n;
    n = 0;
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= w;
    avs_read_i      <= !w;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (n >= 20) begin
      n_errors++;
      stop_test();
    end
    if (!w) chk(nm, d, avs_readdata_o);
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(posedge clk_i);
  endtask
  // Main sequence: velocity mode, position mode, limits, following error, loss of SYNC.
  initial begin
    {n_errors, comparisons} = '0;
    {sys_rst_i, avs_read_i, avs_write_i, sync_run} = 4'h8;
    {avs_address_i, avs_writedata_i} = '0;
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    acc(1'b0, OFS_IP_INDEX, 32'hFD, "ip index");
    acc(1'b1, OFS_IP_INDEX, 32'h02, "");
    acc(1'b0, OFS_IP_INDEX, 32'hFD, "ip index kept");
    acc(1'b0, 8'h80, 32'h0, "unmapped");
    acc(1'b1, OFS_MODE, 32'h9, "");
    acc(1'b1, OFS_TGT_VEL, 32'd100, "");
    acc(1'b1, OFS_VEL_OFS, 32'd5, "");
    acc(1'b1, OFS_TRQ_OFS, 32'h123, "");
    acc(1'b1, OFS_CONTROL, 32'h1, "");
    sync_run <= 1'b1;
    repeat (30) @(posedge clk_i);
    chk("status vel", 32'h1100, {16'h0, statusword_o});
    chk("vel demand", 32'd105, demand_vel_o);
    chk("enable", 32'h1, {31'h0, drive_enable_o});
    chk("torque", 32'h123, {16'h0, torque_offset_o});
    acc(1'b1, OFS_MAX_SPEED, 32'd50, "");
    repeat (10) @(posedge clk_i);
    chk("vel capped", 32'd50, demand_vel_o);
    acc(1'b1, OFS_MAX_SPEED, 32'h7FFFFFFF, "");
    acc(1'b1, OFS_MODE, 32'h8, "");
    acc(1'b1, OFS_TGT_POS, 32'd40, "");
    acc(1'b1, OFS_TGT_POS, 32'd40, "");
    repeat (40) @(posedge clk_i);
    chk("pos demand", 32'd40, demand_pos_o);
    chk("status pos", 32'h1100, {16'h0, statusword_o});
    acc(1'b1, OFS_SW_MAX, 32'd30, "");
    repeat (30) @(posedge clk_i);
    chk("pos clamped", 32'd30, demand_pos_o);
    chk("limit bit", 32'h1900, {16'h0, statusword_o});
    acc(1'b1, OFS_FE_TIMEOUT, 32'd1, "");
    acc(1'b1, OFS_CONTROL, 32'h3, "");
    repeat (50) @(posedge clk_i);
    chk("follow error", 32'h3900, {16'h0, statusword_o});
    sync_run <= 1'b0;
    repeat (40) @(posedge clk_i);
    chk("sync lost", 32'h0, {31'h0, statusword_o[SW_SYNC]});
    acc(1'b1, OFS_RANGE_MIN, 32'h0, "");
    acc(1'b1, OFS_RANGE_MAX, 32'd19, "");
    acc(1'b1, OFS_CONTROL, 32'h9, "");
    repeat (30) @(posedge clk_i);
    chk("pos wrapped", 32'd20, demand_pos_o);
    chk("status wrap", 32'h1000, {16'h0, statusword_o});
    acc(1'b1, OFS_CONTROL, 32'h5, "");
    repeat (5) @(posedge clk_i);
    chk("qs enable", 32'h0, {31'h0, drive_enable_o});
    chk("qs follow", 32'h0, {31'h0, statusword_o[SW_FOLLOW]});
    stop_test();
  end
endmodule
